// ==== verilog/clock_config_select.sv ====
// Start-up configuration selection and reference-source selection
`timescale 1ns/1ps
`default_nettype none
module clock_config_select #(
    parameter int SETTLE_CYCLES = clock_config_pkg::SETTLE_CYCLES,
    parameter int LOAD_CYCLES = clock_config_pkg::LOAD_CYCLES
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic bootstrap_refout_in,
    output logic bootstrap_refout_out,
    output logic bootstrap_refout_oe_n,
    input wire logic ref_clk_en,
    input wire logic dual_pin_hi_in,
    input wire logic dual_pin_lo_in,
    output logic i2c_enable,
    output logic i2c_sda_in,
    output logic i2c_scl_in,
    input wire clock_config_pkg::reg_write_s reg_write,
    output logic [7:0] input_source_config,
    input wire logic stored_i2c_default_flag,
    input wire logic [1:0] switchover_mode_field,
    input wire logic input_select_pin,
    output clock_config_pkg::load_req_s load_req,
    input wire logic load_done,
    output logic load_busy,
    output logic [2:0] active_config,
    output logic select_differential,
    output logic spread_via_fod
);
    // ********************************
    // Parameter checks
    // ********************************
    if (SETTLE_CYCLES < 2 || LOAD_CYCLES < 2) begin : g_bad_count
        $error("clock_config_select: counts must be at least 2");
    end

    logic rst_meta;
    logic rst_n;
    logic [2:0] boot_sync;
    logic [2:0] hi_sync;
    logic [2:0] lo_sync;
    logic [2:0] csel_sync;
    logic bootstrap_high;
    logic sel_hi;
    logic sel_lo;
    logic csel;
    logic [31:0] timer;
    logic [1:0] last_sel;
    logic load_pending;
    clock_config_pkg::load_state_e state;
    clock_config_pkg::load_state_e next_state;

    // ********************************
    // Reset release
    // ********************************
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // Three-stage synchronisers on pins; a change counts when stages 2 and 3 agree
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            boot_sync <= 3'h0;
            hi_sync <= 3'h0;
            lo_sync <= 3'h0;
            csel_sync <= 3'h0;
        end else begin
            boot_sync <= {boot_sync[1:0], bootstrap_refout_in};
            hi_sync <= {hi_sync[1:0], dual_pin_hi_in};
            lo_sync <= {lo_sync[1:0], dual_pin_lo_in};
            csel_sync <= {csel_sync[1:0], input_select_pin};
        end
    end

    // Filtered pin levels
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            sel_hi <= 1'b0;
            sel_lo <= 1'b0;
            csel <= 1'b0;
        end else begin
            if (hi_sync[1] == hi_sync[2]) begin
                sel_hi <= hi_sync[2];
            end
            if (lo_sync[1] == lo_sync[2]) begin
                sel_lo <= lo_sync[2];
            end
            if (csel_sync[1] == csel_sync[2]) begin
                csel <= csel_sync[2];
            end
        end
    end

    // ********************************
    // Load sequencer
    // ********************************
    always_comb begin
        next_state = state;
        unique case (state)
            clock_config_pkg::ST_SAMPLE: begin
                if (timer == 32'(clock_config_pkg::BOOT_SAMPLE_CYCLES)) begin
                    next_state = clock_config_pkg::ST_BOOT_LOAD;
                end
            end
            clock_config_pkg::ST_BOOT_LOAD: begin
                if (load_done) begin
                    next_state = clock_config_pkg::ST_SETTLE; // see [R16]
                end
            end
            clock_config_pkg::ST_SETTLE: begin
                if (timer >= 32'(SETTLE_CYCLES)) begin
                    next_state = clock_config_pkg::ST_RUN; // see [R7]
                end
            end
            clock_config_pkg::ST_RUN: begin
                if (bootstrap_high && !stored_i2c_default_flag && {sel_hi, sel_lo} != last_sel) begin
                    next_state = clock_config_pkg::ST_RELOAD; // see [R7]
                end
            end
            clock_config_pkg::ST_RELOAD: begin
                if (!load_pending && timer >= 32'(LOAD_CYCLES)) begin
                    next_state = clock_config_pkg::ST_RUN; // see [R9]
                end
            end
            default: next_state = clock_config_pkg::ST_SAMPLE;
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= clock_config_pkg::ST_SAMPLE;
        end else begin
            state <= next_state;
        end
    end

    // Cycle timer restarted on every state change
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer <= 32'h0;
        end else if (next_state != state) begin
            timer <= 32'h0;
        end else if (timer != 32'hffffffff) begin
            timer <= timer + 32'h1;
        end
    end

    // Bootstrap level caught once at the end of sampling
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bootstrap_high <= 1'b0;
        end else if (state == clock_config_pkg::ST_SAMPLE && next_state == clock_config_pkg::ST_BOOT_LOAD) begin
            bootstrap_high <= boot_sync[2] & boot_sync[1]; // see [R1]
        end
    end

    // Load requests and selected configuration
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            load_req <= '0;
            active_config <= 3'h0;
            last_sel <= 2'h0;
            load_pending <= 1'b0;
        end else begin
            load_req.start <= 1'b0;
            if (load_done) begin
                load_pending <= 1'b0;
            end
            if (state == clock_config_pkg::ST_SAMPLE && next_state == clock_config_pkg::ST_BOOT_LOAD) begin
                load_req.start <= 1'b1;
                load_pending <= 1'b1;
                last_sel <= {sel_hi, sel_lo};
                if (boot_sync[2] & boot_sync[1]) begin
                    load_req.config_id <= {1'b0, sel_hi, sel_lo}; // see [R5] [R6]
                    active_config <= {1'b0, sel_hi, sel_lo};
                end else if (stored_i2c_default_flag) begin
                    load_req.config_id <= clock_config_pkg::CFG_I2C_DEFAULTS; // see [R5]
                    active_config <= clock_config_pkg::CFG_I2C_DEFAULTS;
                end else begin
                    load_req.config_id <= 3'h0; // see [R5]
                    active_config <= 3'h0;
                end
            end else if (state == clock_config_pkg::ST_RUN && next_state == clock_config_pkg::ST_RELOAD) begin
                load_req.start <= 1'b1; // see [R7] [R10]
                load_pending <= 1'b1;
                load_req.config_id <= {1'b0, sel_hi, sel_lo};
                active_config <= {1'b0, sel_hi, sel_lo};
                last_sel <= {sel_hi, sel_lo};
            end
        end
    end

    assign load_busy = (state == clock_config_pkg::ST_BOOT_LOAD) || (state == clock_config_pkg::ST_RELOAD);

    // ********************************
    // Pin roles
    // ********************************
    // I2C is served only once the power-on load has finished
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            i2c_enable <= 1'b0;
        end else begin
            i2c_enable <= !bootstrap_high && state != clock_config_pkg::ST_SAMPLE
                          && state != clock_config_pkg::ST_BOOT_LOAD; // see [R3] [R16]
        end
    end

    // Dual pins passed to the I2C slave only in I2C role; idle high otherwise
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            i2c_sda_in <= 1'b1;
            i2c_scl_in <= 1'b1;
        end else if (i2c_enable) begin
            i2c_sda_in <= hi_sync[2]; // see [R3]
            i2c_scl_in <= lo_sync[2];
        end else begin
            i2c_sda_in <= 1'b1; // see [R2]
            i2c_scl_in <= 1'b1;
        end
    end

    // Bootstrap pin turns into the reference output after sampling
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bootstrap_refout_oe_n <= 1'b1;
            bootstrap_refout_out <= 1'b0;
        end else begin
            bootstrap_refout_oe_n <= (state == clock_config_pkg::ST_SAMPLE); // see [R4]
            bootstrap_refout_out <= (state != clock_config_pkg::ST_SAMPLE) & ref_clk_en;
        end
    end

    // ********************************
    // Input source register and reference selection
    // ********************************
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            input_source_config <= clock_config_pkg::INPUT_SOURCE_CONFIG_RESET;
        end else if (i2c_enable && reg_write.valid
                     && reg_write.addr == clock_config_pkg::INPUT_SOURCE_CONFIG_ADDR) begin
            input_source_config <= reg_write.data; // see [R10] [R12]
        end
    end

    // Selection changes only when the new choice is stable; the mux itself is glitch-free downstream
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            select_differential <= 1'b0;
        end else if (!switchover_mode_field[1]) begin // see [R14]
            select_differential <= input_source_config[clock_config_pkg::PRIMARY_SOURCE_POS] ^ csel; // see [R11] [R15]
        end
    end

    // Spread is always produced by the fractional dividers
    assign spread_via_fod = 1'b1; // see [R13]

endmodule // clock_config_select
`default_nettype wire

// ==== verilog/clock_config_pkg.sv ====
// Constants and carriers for the start-up configuration and reference selection block
// Behaviour
// [R1] Latch the bootstrap pin level once at power-on; it fixes the dual-pin roles.
// [R2] Bootstrap high: the two dual pins are configuration select inputs.
// [R3] Bootstrap low or floating: the dual pins act as I2C data and clock.
// [R4] After sampling, the bootstrap pin drives the reference clock output.
// [R5] Bootstrap high loads configuration 0..3 from selects; low loads defaults or configuration 0.
// [R6] Host ties selects high or low at power-up; a floating select reads low.
// [R7] Select changes count only after 10 ms, bootstrap high and stored flag 0.
// [R8] Host changes only one select input at a time.
// [R9] After a select change, a load of 1 ms runs undisturbed.
// [R10] Bootstrap low: selects are ignored; only I2C register writes change the configuration.
// [R11] Manual mode: source bit XOR select pin 0 picks crystal, 1 picks differential.
// [R12] Primary source bit sits at bit 1 of input_source_config.
// [R13] Spread spectrum is applied through the fractional output dividers.
// [R14] Switchover-mode upper bit 0 means manual switchover mode.
// [R15] Reference changes switch without output glitches.
// [R16] The power-on load finishes before I2C or select changes are acted on.
`default_nettype none
package clock_config_pkg;
    // ********************************
    // Timing
    // ********************************
    localparam int CLK_HZ = 25_000_000;
    localparam int SETTLE_MS = 10;
    localparam int LOAD_MS = 1;
    localparam int SETTLE_CYCLES = CLK_HZ / 1000 * SETTLE_MS;
    localparam int LOAD_CYCLES = CLK_HZ / 1000 * LOAD_MS;
    localparam int BOOT_SAMPLE_CYCLES = 16;
    // ********************************
    // Register map
    // ********************************
    localparam logic [7:0] INPUT_SOURCE_CONFIG_ADDR = 8'h13;
    localparam int PRIMARY_SOURCE_POS = 1;
    localparam int MODE_HI_POS = 3;
    localparam logic [7:0] INPUT_SOURCE_CONFIG_RESET = 8'h00;
    // ********************************
    // Configuration codes
    // ********************************
    localparam logic [2:0] CFG_I2C_DEFAULTS = 3'h4;
    // Register write from the I2C slave
    typedef struct packed {
        logic valid;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_write_s;
    // Configuration load request towards the register bank
    typedef struct packed {
        logic start;
        logic [2:0] config_id;
    } load_req_s;
    // Load sequencer states
    typedef enum logic [2:0] {
        ST_SAMPLE = 3'b000,
        ST_BOOT_LOAD = 3'b001,
        ST_SETTLE = 3'b011,
        ST_RUN = 3'b010,
        ST_RELOAD = 3'b110
    } load_state_e;
endpackage
`default_nettype wire

// ==== sim/clock_config_select_checker.sv ====
// Assertion checker for the start-up configuration select block
`timescale 1ns/1ps
`default_nettype none
module clock_config_select_checker (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic bootstrap_refout_out,
    input wire logic bootstrap_refout_oe_n,
    input wire logic ref_clk_en,
    input wire logic i2c_enable,
    input wire logic i2c_sda_in,
    input wire logic i2c_scl_in,
    input wire clock_config_pkg::reg_write_s reg_write,
    input wire logic [7:0] input_source_config,
    input wire logic [1:0] switchover_mode_field,
    input wire logic input_select_pin,
    input wire clock_config_pkg::load_req_s load_req,
    input wire logic load_busy,
    input wire logic select_differential,
    input wire logic spread_via_fod
);
    logic [3:0] up_cnt;
    // Cycles since reset release, saturating, so the source check skips the sync start-up
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) up_cnt <= 4'h0;
        else if (up_cnt != 4'hf) up_cnt <= up_cnt + 4'h1;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // Source pick inputs quiet and manual mode set
    sequence s_src_quiet;
        $stable(input_select_pin) && $stable(input_source_config) && !switchover_mode_field[1] && up_cnt == 4'hf;
    endsequence
    property p_src_pick;
        s_src_quiet [*6]
            |-> select_differential == (input_source_config[clock_config_pkg::PRIMARY_SOURCE_POS] ^ input_select_pin);
    endproperty
    a_src_pick: assert property (p_src_pick) else $error("reference source pick wrong");
    property p_out_drive;
        !bootstrap_refout_oe_n && !$past(bootstrap_refout_oe_n) |-> bootstrap_refout_out == $past(ref_clk_en);
    endproperty
    a_out_drive: assert property (p_out_drive) else $error("reference output level wrong");
    property p_oe_hold;
        !bootstrap_refout_oe_n |=> !bootstrap_refout_oe_n;
    endproperty
    a_oe_hold: assert property (p_oe_hold) else $error("pin went back to input");
    property p_reg_write;
        reg_write.valid && i2c_enable && reg_write.addr == clock_config_pkg::INPUT_SOURCE_CONFIG_ADDR
            |=> input_source_config == $past(reg_write.data);
    endproperty
    a_reg_write: assert property (p_reg_write) else $error("register write lost");
    property p_write_refused;
        reg_write.valid && !i2c_enable |=> $stable(input_source_config);
    endproperty
    a_write_refused: assert property (p_write_refused) else $error("write taken without bus");
    property p_no_reload;
        i2c_enable |-> !load_req.start;
    endproperty
    a_no_reload: assert property (p_no_reload) else $error("load started in bus role");
    property p_pins_idle;
        !i2c_enable |-> i2c_sda_in && i2c_scl_in;
    endproperty
    a_pins_idle: assert property (p_pins_idle) else $error("bus lines passed while disabled");
    property p_busy_excl;
        load_busy |-> !i2c_enable;
    endproperty
    a_busy_excl: assert property (p_busy_excl) else $error("bus enabled during load");
    property p_load_gap;
        $rose(load_busy) |-> load_busy [*8];
    endproperty
    a_load_gap: assert property (p_load_gap) else $error("load ended too soon");
    property p_spread;
        spread_via_fod;
    endproperty
    a_spread: assert property (p_spread) else $error("spread path off");
endmodule // clock_config_select_checker
bind clock_config_select clock_config_select_checker u_checker (.sys_clk(sys_clk), .resetn(resetn),
    .bootstrap_refout_out(bootstrap_refout_out), .bootstrap_refout_oe_n(bootstrap_refout_oe_n),
    .ref_clk_en(ref_clk_en), .i2c_enable(i2c_enable), .i2c_sda_in(i2c_sda_in), .i2c_scl_in(i2c_scl_in),
    .reg_write(reg_write), .input_source_config(input_source_config), .switchover_mode_field(switchover_mode_field),
    .input_select_pin(input_select_pin), .load_req(load_req), .load_busy(load_busy),
    .select_differential(select_differential), .spread_via_fod(spread_via_fod));
`default_nettype wire

// ==== sim/far_host_model.sv ====
// Host-side model: strap level, select GPIOs and the register bank's load answer
`timescale 1ns/1ps
`default_nettype none
module far_host_model (
    input wire logic sys_clk,
    input wire logic boot_level,
    input wire logic [1:0] sel_cmd,
    input wire logic pin_out,
    input wire logic pin_oe_n,
    input wire logic load_start,
    output logic boot_pin,
    output logic dual_hi,
    output logic dual_lo,
    output logic load_done
);
    int wait_cnt = 0;
    // Strap level while the device listens, the device's own drive afterwards
    assign boot_pin = pin_oe_n ? boot_level : pin_out;
    // Selects start low, as a floating pin reads
    initial begin
        dual_hi = 1'b0;
        dual_lo = 1'b0;
        load_done = 1'b0;
    end
    // GPIO drive moves only one select pin per cycle, high one first
    always @(negedge sys_clk) begin
        if (dual_hi != sel_cmd[1]) dual_hi <= sel_cmd[1];
        else dual_lo <= sel_cmd[0];
    end
    // Register bank answers each load request after a fixed delay
    always @(posedge sys_clk) begin
        load_done <= (wait_cnt == 1);
        if (load_start) wait_cnt <= 12;
        else if (wait_cnt != 0) wait_cnt <= wait_cnt - 1;
    end
endmodule // far_host_model
`default_nettype wire

// ==== sim/test_clock_config_select.sv ====
// Self-checking bench for the start-up configuration select block
`timescale 1ns/1ps
`default_nettype none
module test_clock_config_select;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic boot_level = 1'b0;
    logic [1:0] sel_cmd = 2'b00;
    logic ref_clk_en = 1'b0;
    logic flag = 1'b0;
    logic [1:0] mode = 2'b00;
    logic clk_sel = 1'b0;
    clock_config_pkg::reg_write_s reg_write = '0;
    clock_config_pkg::load_req_s load_req;
    wire logic boot_pin, dual_hi, dual_lo, pin_out, pin_oe_n, load_done, i2c_en, sda, scl, busy, diff;
    wire logic [7:0] src_cfg;
    wire logic [2:0] act_cfg;
    int err_count = 0;
    int checked = 0;
    // Rows: {bootstrap, select hi, select lo, stored flag} and {bus role, configuration}
    logic [3:0] row_in [6] = '{4'b1000, 4'b1010, 4'b1100, 4'b1110, 4'b0001, 4'b0110};
    logic [3:0] row_out [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'hc, 4'h8};
    far_host_model u_host (.sys_clk(sys_clk), .boot_level(boot_level), .sel_cmd(sel_cmd), .pin_out(pin_out),
        .pin_oe_n(pin_oe_n), .load_start(load_req.start), .boot_pin(boot_pin), .dual_hi(dual_hi),
        .dual_lo(dual_lo), .load_done(load_done));
    clock_config_select #(.SETTLE_CYCLES(50), .LOAD_CYCLES(20)) u_dut (.sys_clk(sys_clk), .resetn(resetn),
        .bootstrap_refout_in(boot_pin), .bootstrap_refout_out(pin_out), .bootstrap_refout_oe_n(pin_oe_n),
        .ref_clk_en(ref_clk_en), .dual_pin_hi_in(dual_hi), .dual_pin_lo_in(dual_lo), .i2c_enable(i2c_en),
        .i2c_sda_in(sda), .i2c_scl_in(scl), .reg_write(reg_write), .input_source_config(src_cfg),
        .stored_i2c_default_flag(flag), .switchover_mode_field(mode), .input_select_pin(clk_sel),
        .load_req(load_req), .load_done(load_done), .load_busy(busy), .active_config(act_cfg),
        .select_differential(diff), .spread_via_fod());
    // Clock and a toggling reference level
    initial begin
        forever #20 sys_clk = ~sys_clk;
    end
    always @(negedge sys_clk) ref_clk_en <= ~ref_clk_en;
    task automatic cmp(input logic [7:0] got, input logic [7:0] exp, input string what);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic complete_run();
        $display("Counts: %0d checked, %0d mismatches", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // Reset with the given strap, selects and flag, held six cycles
    task automatic power_up(input logic [3:0] r);
        @(negedge sys_clk);
        resetn = 1'b0;
        {boot_level, sel_cmd, flag} = r;
        repeat (6) @(negedge sys_clk);
        resetn = 1'b1;
    endtask
    task automatic wait_start(input int limit);
        int n;
        n = 0;
        while (load_req.start !== 1'b1 && n < limit) begin
            @(negedge sys_clk);
            n++;
        end
        if (n >= limit) begin
            cmp(8'h0, 8'h1, "load request timeout");
            complete_run();
        end
    endtask
    task automatic no_start(input int n);
        repeat (n) begin
            @(negedge sys_clk);
            if (load_req.start === 1'b1) cmp(8'h1, 8'h0, "unexpected load");
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_write = '{1'b1, a, d};
        @(negedge sys_clk);
        reg_write.valid = 1'b0;
    endtask
    // Power-on table, then bus role, source pick and run-time select changes
    initial begin
        for (int i = 0; i < 6; i++) begin
            power_up(row_in[i]);
            wait_start(40);
            cmp(8'(load_req.config_id), 8'(row_out[i][2:0]), "power-on config");
            cmp(8'(act_cfg), 8'(row_out[i][2:0]), "active config");
            repeat (30) @(negedge sys_clk);
            cmp(8'(i2c_en), 8'(row_out[i][3]), "bus role");
            cmp(8'(pin_oe_n), 8'h0, "refout drive");
            $display("row %0d done", i);
        end
        cmp(src_cfg, 8'h00, "register reset");
        sel_cmd = 2'b01;
        no_start(80);
        cmp(8'({sda, scl}), 8'h01, "bus lines");
        for (int k = 0; k < 4; k++) begin
            wr(8'h13, {6'h00, k[1], 1'b0});
            clk_sel = k[0];
            repeat (8) @(negedge sys_clk);
            cmp(8'(diff), 8'(k[1] ^ k[0]), "source pick");
        end
        wr(8'h14, 8'hff);
        cmp(src_cfg, 8'h02, "other address");
        mode = 2'b10;
        clk_sel = 1'b0;
        repeat (8) @(negedge sys_clk);
        cmp(8'(diff), 8'h00, "frozen pick");
        mode = 2'b01;
        repeat (8) @(negedge sys_clk);
        cmp(8'(diff), 8'h01, "manual pick");
        $display("bus role test done");
        // Settle window ends 50 cycles after the boot load; the change is taken right then
        power_up(4'b1000);
        wait_start(40);
        wr(8'h13, 8'h02);
        cmp(src_cfg, 8'h00, "write refused");
        sel_cmd = 2'b01;
        no_start(60);
        wait_start(10);
        cmp(8'(load_req.config_id), 8'h01, "reload config");
        // Next change waits for the load answer and the 20-cycle load window
        sel_cmd = 2'b11;
        no_start(20);
        wait_start(10);
        cmp(8'(load_req.config_id), 8'h03, "second reload");
        cmp(8'(act_cfg), 8'h03, "active after reload");
        // Stored flag set: bootstrap high still loads from selects, later changes ignored
        power_up(4'b1111);
        wait_start(40);
        cmp(8'(load_req.config_id), 8'h03, "flag ignored at boot");
        sel_cmd = 2'b10;
        no_start(120);
        $display("select change test done");
        complete_run();
    end
endmodule // test_clock_config_select
`default_nettype wire
